// [rmt_engine.sv]
// march c / march x self-test engine driving a byte-wide synchronous sram
`timescale 1ns/100ps
module rmt_engine import rmt_pkg::*; (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // controller side
    input  wire rmt_cmd_t     cmd,
    output logic              busy,
    output logic              done,
    output logic [7:0]        status,
    // sram under test
    output rmt_mem_req_t      mem_req,
    input  wire logic [7:0]   mem_rdata
);
    typedef enum logic [2:0] { S_IDLE, S_ENTRY, S_READ, S_WAIT, S_CMP, S_WRITE, S_ADV,
                               S_DONE } rmt_state_t;

    rmt_state_t        state_reg, state_next;
    rmt_mode_t         mode_reg;
    logic [ADDR_W-1:0] base_reg;
    logic [LEN_W-1:0]  len_reg;
    logic [LEN_W-1:0]  off_reg;
    logic [2:0]        elem_reg;
    logic              fail_reg;
    logic              busy_reg;
    logic              done_reg;
    logic [7:0]        status_reg;
    rmt_mem_req_t      mem_reg;
    rmt_elem_t         desc;
    logic              bad_range;
    logic              last_cell;
    logic              last_elem;
    logic              mismatch;
    logic [ADDR_W-1:0] cell_addr;
    logic [16:0]       range_end;

    assign desc      = elem_desc(mode_reg, elem_reg);
    assign range_end = {1'b0, cmd.start_addr} + {1'b0, cmd.length};
    assign bad_range = (cmd.length == '0) || (range_end > MEM_BYTES);
    assign last_cell = (off_reg == len_reg - 16'h0001);
    assign last_elem = (elem_reg == ((mode_reg == MODE_MARCH_C) ? LAST_C : LAST_X));
    assign mismatch  = (mem_rdata != pattern(desc.rd_one));
    // descending elements walk from the top of the range down
    assign cell_addr = desc.down ? ADDR_W'(base_reg + len_reg - 16'h0001 - off_reg)
                                 : ADDR_W'(base_reg + off_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:  if (cmd.start) state_next = bad_range ? S_DONE : S_ENTRY;
            S_ENTRY: state_next = desc.do_read ? S_READ : S_WRITE;
            S_READ:  state_next = S_WAIT;
            S_WAIT:  state_next = S_CMP;
            // a mismatch ends the run early: the verdict cannot change afterwards
            S_CMP:   state_next = mismatch ? S_DONE : (desc.do_write ? S_WRITE : S_ADV);
            S_WRITE: state_next = S_ADV;
            S_ADV:   state_next = (last_cell && last_elem) ? S_DONE : S_ENTRY;
            S_DONE:  state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) state_reg <= S_IDLE;
        else       state_reg <= state_next;
    end

    // command capture; the operands are held so the controller may change them mid-run
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_MARCH_C;
            base_reg <= '0;
            len_reg  <= '0;
        end else if (state_reg == S_IDLE && cmd.start) begin
            mode_reg <= cmd.mode;
            base_reg <= cmd.start_addr;
            len_reg  <= cmd.length;
        end
    end

    // cell and element walk
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            off_reg  <= '0;
            elem_reg <= '0;
        end else if (state_reg == S_IDLE) begin
            off_reg  <= '0;
            elem_reg <= '0;
        end else if (state_reg == S_ADV) begin
            if (last_cell) begin
                off_reg  <= '0;
                // the index stops on the last element so the pass check still sees it
                if (!last_elem) elem_reg <= elem_reg + 3'h1;
            end else begin
                off_reg  <= off_reg + 16'h0001;
            end
        end
    end

    // sram request; contents are left with the final pattern, never restored
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mem_reg <= '0;
        end else begin
            mem_reg.en    <= (state_reg == S_READ) || (state_reg == S_WRITE);
            mem_reg.we    <= (state_reg == S_WRITE);
            mem_reg.addr  <= cell_addr;
            mem_reg.wdata <= pattern(desc.wr_one);
        end
    end

    // verdict
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fail_reg <= 1'b0;
        end else if (state_reg == S_IDLE && cmd.start) begin
            fail_reg <= bad_range;
        end else if (state_reg == S_CMP && mismatch) begin
            fail_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            status_reg <= STAT_PASS;
        end else begin
            done_reg <= (state_reg == S_DONE);
            if (state_reg == S_IDLE && cmd.start) begin
                busy_reg <= 1'b1;
            end else if (state_reg == S_DONE) begin
                busy_reg   <= 1'b0;
                status_reg <= fail_reg ? STAT_FAIL : STAT_PASS;
            end
        end
    end

    assign busy    = busy_reg;
    assign done    = done_reg;
    assign status  = status_reg;
    assign mem_req = mem_reg;

    AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_IDLE && cmd.start) |=> busy)
        else $error("busy not raised after start");

    AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
        done |-> !busy ##1 !done)
        else $error("done longer than one cycle or busy still high");

    AST_BAD_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_IDLE && cmd.start && bad_range)
        |=> !mem_req.en ##1 (done && status == STAT_FAIL && !mem_req.en))
        else $error("bad range not failed at once");

    AST_BYTE_PATTERN: assert property (@(posedge core_clk) disable iff (!nrst)
        // odd elements write ones in both modes, even ones write zeros
        mem_req.we |-> (mem_req.wdata == (elem_reg[0] ? PAT_ONE : PAT_ZERO)))
        else $error("write data not a byte pattern");

    AST_MISMATCH_FAILS: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_CMP && mismatch) |=> ##1 (done && status == STAT_FAIL))
        else $error("mismatch not reported");

    AST_IN_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_req.en |-> (mem_req.addr >= base_reg &&
                        {1'b0, mem_req.addr} < {1'b0, base_reg} + {1'b0, len_reg}))
        else $error("access outside the tested range");

    AST_READ_THEN_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_CMP && !mismatch && desc.do_write)
        |=> ##1 (mem_req.en && mem_req.we && mem_req.addr == $past(mem_req.addr, 3)))
        else $error("write did not follow read on the same cell");

    AST_FIRST_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        (mem_req.en && elem_reg == 3'h0) |-> (mem_req.we && mem_req.wdata == PAT_ZERO))
        else $error("first element not write zero");

    AST_ELEM_COUNT: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_DONE && !fail_reg)
        |-> elem_reg == ((mode_reg == MODE_MARCH_C) ? LAST_C : LAST_X))
        else $error("pass reported before all elements");

    AST_DOWN_START: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_READ && desc.down && off_reg == '0)
        |=> mem_req.addr == ADDR_W'(base_reg + len_reg - 16'h0001))
        else $error("descending pass not started at top");

    AST_BUSY_ENDS: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(busy) |-> done)
        else $error("busy dropped without done");

    AST_DONE_AFTER_RUN: assert property (@(posedge core_clk) disable iff (!nrst)
        done |-> $past(busy))
        else $error("done without a run");

    AST_STATUS_HOLDS: assert property (@(posedge core_clk) disable iff (!nrst)
        !done |-> $stable(status))
        else $error("status changed outside done");

    AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (!nrst)
        !busy |-> !mem_req.en)
        else $error("memory access while not busy");

    AST_ONE_CYCLE_ACCESS: assert property (@(posedge core_clk) disable iff (!nrst)
        mem_req.en |=> !mem_req.en)
        else $error("access strobe longer than one cycle");

    // element 2 reads ones in both modes, ascending for c, descending for x
    AST_C_THIRD_UP: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_READ && mode_reg == MODE_MARCH_C && elem_reg == 3'h2)
        |-> (desc.rd_one && !desc.down && desc.do_write && !desc.wr_one))
        else $error("third march c element wrong");

    AST_X_THIRD_DOWN: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_reg == S_READ && mode_reg == MODE_MARCH_X && elem_reg == 3'h2)
        |-> (desc.rd_one && desc.down && desc.do_write && !desc.wr_one))
        else $error("third march x element wrong");
endmodule : rmt_engine

// [rmt_pkg.sv]
// constants, types and helpers for the ram march self-test engine
// Operation
// - March C runs six elements holding ten operations over the range.
// - each element finishes all operations on one cell before moving on, covering all.
// - March C writes zero everywhere, then ascends reading zero and writing one.
// - third March C element ascends, reads ones, writes zeros.
// - two descending passes (r0,w1 then r1,w0), then a final read of zeros.
// - any read differing from the expected pattern is flagged as a failure.
// - March X runs four elements: w0, up r0 w1, down r1 w0, r0.
// - March X is shorter, catching stuck-at, transition, inversion coupling, decoder faults.
// - the run overwrites every cell in range and never restores them.
// - any sub-range of the memory may be tested.
// - every memory access is one byte wide.
// - a one-byte range is accepted; longer ranges are advised for coverage.
// - status is 0 on pass, 1 on mismatch or invalid range.
// - a run covers at most 65535 bytes, so a whole-memory run is not possible.
package rmt_pkg;
    localparam int          ADDR_W    = 16;
    localparam int          LEN_W     = 16;
    localparam logic [16:0] MEM_BYTES = 17'h10000;
    localparam logic [7:0]  PAT_ZERO  = 8'h00;
    localparam logic [7:0]  PAT_ONE   = 8'hff;
    localparam logic [2:0]  LAST_C    = 3'h5;
    localparam logic [2:0]  LAST_X    = 3'h3;
    localparam logic [7:0]  STAT_PASS = 8'h00;
    localparam logic [7:0]  STAT_FAIL = 8'h01;

    typedef enum logic { MODE_MARCH_C, MODE_MARCH_X } rmt_mode_t;

    typedef struct packed {
        logic              start;
        rmt_mode_t         mode;
        logic [ADDR_W-1:0] start_addr;
        logic [LEN_W-1:0]  length;
    } rmt_cmd_t;

    typedef struct packed {
        logic              en;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } rmt_mem_req_t;

    typedef struct packed {
        logic do_read;
        logic rd_one;
        logic do_write;
        logic wr_one;
        logic down;
    } rmt_elem_t;

    // march X reuses the C elements 0, 1, 4 and 5
    function automatic rmt_elem_t elem_desc(rmt_mode_t m, logic [2:0] i);
        logic [2:0] k;
        rmt_elem_t  d;
        k = i;
        if (m == MODE_MARCH_X) begin
            case (i)
                3'h2:    k = 3'h4;
                3'h3:    k = 3'h5;
                default: k = i;
            endcase
        end
        case (k)
            3'h0:    d = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            3'h1:    d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            3'h2:    d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            3'h3:    d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            3'h4:    d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            default: d = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        endcase
        return d;
    endfunction : elem_desc

    function automatic logic [7:0] pattern(logic one);
        return one ? PAT_ONE : PAT_ZERO;
    endfunction : pattern
endpackage : rmt_pkg

// [rmt_sram_model.sv]
// behavioural byte-wide sync sram under test, with one injectable stuck-at-one bit
`timescale 1ns/100ps
module rmt_sram_model import rmt_pkg::*; (
    // clock
    input  wire logic         core_clk,
    // engine side
    input  wire rmt_mem_req_t mem_req,
    output logic [7:0]        mem_rdata,
    // test control and observation
    input  wire logic         clr,
    input  wire logic         fault_en,
    input  wire logic [15:0]  fault_addr,
    output int                n_acc,
    output logic [15:0]       lo_addr,
    output logic [15:0]       hi_addr
);
    logic [7:0] mem [0:65535];

    // background value, so untouched cells show up if the engine strays
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h5a;
        mem_rdata = 8'h00;
        n_acc     = 0;
        lo_addr   = 16'hffff;
        hi_addr   = 16'h0000;
    end

    always @(posedge core_clk) begin
        if (clr) begin
            n_acc   <= 0;
            lo_addr <= 16'hffff;
            hi_addr <= 16'h0000;
        end else if (mem_req.en) begin
            n_acc <= n_acc + 1;
            if (mem_req.addr < lo_addr) lo_addr <= mem_req.addr;
            if (mem_req.addr > hi_addr) hi_addr <= mem_req.addr;
        end
        if (mem_req.en && mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
        // read data only valid the cycle after the read; otherwise it toggles
        if (mem_req.en && !mem_req.we) begin
            if (fault_en && mem_req.addr == fault_addr) begin
                mem_rdata <= mem[mem_req.addr] | 8'h01;
            end else begin
                mem_rdata <= mem[mem_req.addr];
            end
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : rmt_sram_model

// [test_ram_march_self_test.sv]
// self-checking testbench for the march self-test engine
`timescale 1ns/100ps
module test_ram_march_self_test import rmt_pkg::*; ;
    logic         core_clk;
    logic         nrst;
    rmt_cmd_t     cmd;
    logic         busy;
    logic         done;
    logic [7:0]   status;
    rmt_mem_req_t mem_req;
    logic [7:0]   mem_rdata;
    logic         clr;
    logic         fault_en;
    logic [15:0]  fault_addr;
    int           n_acc;
    logic [15:0]  lo_addr;
    logic [15:0]  hi_addr;
    int           failures = 0;
    int           tests_run = 0;

    rmt_engine dut (.core_clk(core_clk), .nrst(nrst), .cmd(cmd), .busy(busy), .done(done),
        .status(status), .mem_req(mem_req), .mem_rdata(mem_rdata));
    rmt_sram_model sram (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .clr(clr), .fault_en(fault_en), .fault_addr(fault_addr), .n_acc(n_acc),
        .lo_addr(lo_addr), .hi_addr(hi_addr));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("counts: compares=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // one run; only start is held just for the taking edge, mode and range stay on cmd
    task automatic run(input rmt_mode_t m, input logic [15:0] a, input logic [15:0] n);
        int k;
        @(negedge core_clk);
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        cmd = '{1'b1, m, a, n};
        @(negedge core_clk);
        cmd.start = 1'b0;
        chk(busy, 1);
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(negedge core_clk);
            k++;
        end
        chk({busy, done}, 2'b01);
        @(negedge core_clk);
        chk(done, 0);
    endtask : run

    // clean run: status, access count, bounds, contents left behind
    task automatic t_pass(input string nm, input rmt_mode_t m, input logic [15:0] a,
                          input logic [15:0] n, input int per);
        run(m, a, n);
        chk(status, STAT_PASS);
        chk(n_acc, per * n);
        chk(lo_addr, a);
        chk(hi_addr, a + n - 16'h1);
        for (int i = 0; i < n; i++) chk(sram.mem[a + i], PAT_ZERO);
        chk(sram.mem[a - 16'h1], 8'h5a);
        if (32'(a) + 32'(n) < 32'h10000) chk(sram.mem[a + n], 8'h5a);
        // the bench puts the background value back into the tested cells
        for (int i = 0; i < n; i++) sram.mem[a + i] = 8'h5a;
        $display("test %s finished", nm);
    endtask : t_pass

    // a start while busy is dropped: range and mode of the first run stand
    task automatic t_refuse(input string nm);
        fork
            run(MODE_MARCH_X, 16'h0600, 16'h0002);
            begin
                repeat (6) @(negedge core_clk);
                cmd = '{1'b1, MODE_MARCH_C, 16'h0700, 16'h0000};
                @(negedge core_clk);
                cmd.start = 1'b0;
            end
        join
        chk(status, STAT_PASS);
        chk(n_acc, 12);
        chk(hi_addr, 16'h0601);
        $display("test %s finished", nm);
    endtask : t_refuse

    task automatic t_bad(input string nm, input logic [15:0] a, input logic [15:0] n);
        run(MODE_MARCH_C, a, n);
        chk(status, STAT_FAIL);
        chk(n_acc, 0);
        $display("test %s finished", nm);
    endtask : t_bad

    task automatic t_fault(input string nm, input rmt_mode_t m, input logic [15:0] f);
        fault_en   = 1'b1;
        fault_addr = f;
        run(m, 16'h0400, 16'h0008);
        chk(status, STAT_FAIL);
        fault_en = 1'b0;
        $display("test %s finished", nm);
    endtask : t_fault

    initial begin
        #(60000 * 100);
        failures++;
        close_out();
    end

    initial begin
        nrst       = 1'b0;
        cmd        = '0;
        clr        = 1'b0;
        fault_en   = 1'b0;
        fault_addr = 16'h0000;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        chk({busy, done, status}, 10'h000);
        // ranges stay clear of the bench's own storage; only the three fault runs reuse one range
        t_pass("march_c_four", MODE_MARCH_C, 16'h0100, 16'h0004, 10);
        t_pass("march_x_three", MODE_MARCH_X, 16'h0200, 16'h0003, 6);
        t_pass("single_byte", MODE_MARCH_C, 16'h0300, 16'h0001, 10);
        t_pass("top_of_memory", MODE_MARCH_X, 16'hfff0, 16'h0010, 6);
        t_bad("zero_length", 16'h0500, 16'h0000);
        t_bad("past_end", 16'hfff0, 16'h0011);
        t_fault("stuck_c_first", MODE_MARCH_C, 16'h0400);
        t_fault("stuck_c_last", MODE_MARCH_C, 16'h0407);
        t_fault("stuck_x_mid", MODE_MARCH_X, 16'h0403);
        t_refuse("start_while_busy");
        close_out();
    end
endmodule : test_ram_march_self_test
